// ---- vcpp_packer.sv ----
// video color pattern packer: one pattern period in, header and column beats out
//
// Operation
// - symbol width equals bits per plane
// - symbols are at least four bits wide
// - pattern and packet type fixed per packet
// - rows parallel, columns give beats per video period
// - leftmost column goes out first
// - top row in most significant symbol
// - symbols per beat equals parallel samples
// - multi-pixel patterns share one plane
// - pixels per period equal name repeats
// - vertical pair: upper even, lower odd lines
// - 4:2:2 chroma alternates, luma every pixel
// - two-row 4:2:2 beat: luma plus chroma
// - parallel 10-bit planes share one word
// - sequential RGB sends blue, green, red
// - recommended pattern orders for compatibility
// - build-time planes parallel and in sequence
// - 4-bit type in lowest symbol first
// - video type zero, control type fifteen
// - pixels arrive and leave in raster order
`timescale 1ns/1ps
`include "vcpp_defines.svh"
module vcpp_packer #(
   parameter int BPS  = `VCPP_DEF_BPS,
   parameter int ROWS = `VCPP_DEF_ROWS,
   parameter int COLS = `VCPP_DEF_COLS,
   parameter bit [ROWS*COLS-1:0] VSUB_MASK = '0
) (
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     in_valid_i,
   output logic                          in_ready_o,
   input  wire logic                     in_sop_i,
   input  wire logic                     in_eop_i,
   input  wire logic                     in_eol_i,
   input  wire logic [`VCPP_TYPE_W-1:0]  in_type_i,
   // the period word carries whatever pattern the user loads into it
   input  wire logic [ROWS*COLS*BPS-1:0] in_upper_i,
   input  wire logic [ROWS*COLS*BPS-1:0] in_lower_i,
   output logic                          out_valid_o,
   input  wire logic                     out_ready_i,
   output logic [ROWS*BPS-1:0]           out_data_o,
   output logic                          out_sop_o,
   output logic                          out_eop_o
);
   localparam int DW = ROWS*BPS;
   localparam int PW = ROWS*COLS*BPS;
   localparam int CW = (COLS > 1) ? $clog2(COLS) : 1;
   localparam logic [CW-1:0] COL_LAST = CW'(COLS-1);

   typedef struct packed {
      vcpp_pkg::vcpp_state_t  state;
      logic [CW-1:0]          col;
      logic [PW-1:0]          upper;
      logic [PW-1:0]          lower;
      logic [`VCPP_TYPE_W-1:0] ptype;
      logic                   eop;
      logic                   eol;
      logic                   odd_line;
      logic                   in_ready;
   } vcpp_main_t;

   vcpp_main_t st_r;
   vcpp_main_t st_nxt;

   logic                  accept_s;
   logic                  can_load_s;
   logic                  load_s;
   logic                  video_s;
   logic                  last_s;
   logic [DW-1:0]         beat_s;
   logic [DW-1:0]         word_s;
   vcpp_pkg::vcpp_delim_t delim_s;
   vcpp_pkg::vcpp_delim_t delim_q;

   assign accept_s = in_valid_i && st_r.in_ready;
   assign video_s  = (st_r.ptype == `VCPP_TYPE_VIDEO);
   // non-video packets carry one beat per period, column zero only
   assign last_s   = !video_s || (st_r.col == COL_LAST);
   assign load_s   = (st_r.state != vcpp_pkg::VCPP_IDLE) && can_load_s;

   vcpp_col_mux #(
      .BPS       (BPS),
      .ROWS      (ROWS),
      .COLS      (COLS),
      .CW        (CW),
      .VSUB_MASK (VSUB_MASK)
   ) u_mux (
      .upper_i    (st_r.upper),
      .lower_i    (st_r.lower),
      .col_i      (st_r.col),
      .odd_line_i (st_r.odd_line),
      .beat_o     (beat_s)
   );

   always_comb begin
      word_s      = beat_s;
      delim_s.sop = 1'b0;
      delim_s.eop = st_r.eop && last_s;
      if (st_r.state == vcpp_pkg::VCPP_HDR) begin
         // type in the lowest symbol, the rest of the beat cleared
         word_s      = '0;
         word_s[`VCPP_TYPE_W-1:0] = st_r.ptype;
         delim_s.sop = 1'b1;
         delim_s.eop = 1'b0;
      end
   end

   always_comb begin
      st_nxt = st_r;
      case (st_r.state)
         vcpp_pkg::VCPP_IDLE: begin
            if (accept_s) begin
               st_nxt.upper    = in_upper_i;
               st_nxt.lower    = in_lower_i;
               st_nxt.eop      = in_eop_i;
               st_nxt.eol      = in_eol_i;
               st_nxt.col      = '0;
               st_nxt.in_ready = 1'b0;
               if (in_sop_i) begin
                  st_nxt.ptype    = in_type_i;
                  st_nxt.odd_line = `VCPP_PARITY_EVEN;
                  st_nxt.state    = vcpp_pkg::VCPP_HDR;
               end else begin
                  st_nxt.state = vcpp_pkg::VCPP_BEAT;
               end
            end
         end
         vcpp_pkg::VCPP_HDR: begin
            if (load_s) begin
               st_nxt.state = vcpp_pkg::VCPP_BEAT;
            end
         end
         vcpp_pkg::VCPP_BEAT: begin
            if (load_s) begin
               if (last_s) begin
                  st_nxt.state    = vcpp_pkg::VCPP_IDLE;
                  st_nxt.in_ready = 1'b1;
                  if (st_r.eol) begin
                     st_nxt.odd_line = !st_r.odd_line;
                  end
               end else begin
                  st_nxt.col = st_r.col + CW'(1);
               end
            end
         end
         default: begin
            st_nxt.state    = vcpp_pkg::VCPP_IDLE;
            st_nxt.in_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r          <= '0;
         st_r.state    <= vcpp_pkg::VCPP_IDLE;
         st_r.in_ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   vcpp_out_reg #(
      .DW (DW)
   ) u_out (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .load_i     (load_s),
      .data_i     (word_s),
      .delim_i    (delim_s),
      .ready_i    (out_ready_i),
      .can_load_o (can_load_s),
      .valid_o    (out_valid_o),
      .data_o     (out_data_o),
      .delim_o    (delim_q)
   );

   assign in_ready_o = st_r.in_ready;
   assign out_sop_o  = delim_q.sop;
   assign out_eop_o  = delim_q.eop;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   a_sym_width: assert property (BPS >= `VCPP_MIN_SYM_W)
      else $error("symbol width below minimum");

   a_stall_hold: assert property (
      out_valid_o && !out_ready_i |=>
         out_valid_o && $stable(out_data_o) && $stable(out_sop_o) && $stable(out_eop_o))
      else $error("output beat changed while stalled");

   a_header_type: assert property (
      out_valid_o && out_sop_o |->
         (out_data_o[`VCPP_TYPE_W-1:0] == st_r.ptype) &&
         ((out_data_o >> `VCPP_TYPE_W) == '0) && !out_eop_o)
      else $error("header beat malformed");

   a_type_locked: assert property (
      !(accept_s && in_sop_i) |=> $stable(st_r.ptype))
      else $error("packet type changed inside packet");

   a_col_order: assert property (
      load_s && st_r.state == vcpp_pkg::VCPP_BEAT && !last_s |=>
         st_r.col == $past(st_r.col) + CW'(1))
      else $error("columns not sent left to right");

   a_parity_start: assert property (
      accept_s && in_sop_i |=> st_r.odd_line == `VCPP_PARITY_EVEN)
      else $error("packet does not start on an even line");

   a_ready_idle: assert property (
      in_ready_o == (st_r.state == vcpp_pkg::VCPP_IDLE))
      else $error("input ready out of step with state");

   a_ctrl_one_beat: assert property (
      load_s && st_r.state == vcpp_pkg::VCPP_BEAT && !video_s |=>
         st_r.state == vcpp_pkg::VCPP_IDLE)
      else $error("non-video period sent more than one beat");

   a_beat_lands: assert property (
      load_s && st_r.state == vcpp_pkg::VCPP_BEAT |=>
         out_valid_o && out_data_o == $past(beat_s) && !out_sop_o)
      else $error("data beat not presented after load");

   a_hdr_then_beat: assert property (
      accept_s && in_sop_i |=> st_r.state == vcpp_pkg::VCPP_HDR ##[1:300]
         st_r.state == vcpp_pkg::VCPP_BEAT)
      else $error("header state not followed by data");

   c_header: cover property (out_valid_o && out_ready_i && out_sop_o);
   c_stall:  cover property (out_valid_o && !out_ready_i ##1 out_valid_o && out_ready_i);
   c_eop:    cover property (out_valid_o && out_ready_i && out_eop_o);
   c_odd:    cover property (st_r.odd_line && load_s);
endmodule

// ---- vcpp_defines.svh ----
// constants of the video color pattern packer
`ifndef VCPP_DEFINES_SVH
`define VCPP_DEFINES_SVH
`define VCPP_TYPE_W      4
`define VCPP_TYPE_VIDEO  4'h0
`define VCPP_TYPE_CTRL   4'hF
`define VCPP_MIN_SYM_W   4
`define VCPP_DEF_BPS     8
`define VCPP_DEF_ROWS    3
`define VCPP_DEF_COLS    1
`define VCPP_PARITY_EVEN 1'b0
`endif

// ---- vcpp_pkg.sv ----
// types shared by the video color pattern packer
package vcpp_pkg;
   typedef enum logic [1:0] {
      VCPP_IDLE,
      VCPP_HDR,
      VCPP_BEAT
   } vcpp_state_t;

   typedef struct packed {
      logic sop;
      logic eop;
   } vcpp_delim_t;
endpackage

// ---- vcpp_col_mux.sv ----
// picks one pattern column and maps its rows onto the symbols of a beat
`timescale 1ns/1ps
module vcpp_col_mux #(
   parameter int BPS       = 8,
   parameter int ROWS      = 3,
   parameter int COLS      = 1,
   parameter int CW        = 1,
   parameter bit [ROWS*COLS-1:0] VSUB_MASK = '0
) (
   input  wire logic [ROWS*COLS*BPS-1:0] upper_i,
   input  wire logic [ROWS*COLS*BPS-1:0] lower_i,
   input  wire logic [CW-1:0]            col_i,
   input  wire logic                     odd_line_i,
   output logic      [ROWS*BPS-1:0]      beat_o
);
   // element (r,c) sits at index r*COLS+c counted from the msb of the input word
   for (genvar r = 0; r < ROWS; r++) begin : g_row
      logic [BPS-1:0] up_s;
      logic [BPS-1:0] lo_s;
      logic           vsub_s;
      always_comb begin
         up_s   = '0;
         lo_s   = '0;
         vsub_s = 1'b0;
         for (int c = 0; c < COLS; c++) begin
            if (col_i == CW'(c)) begin
               up_s   = upper_i[(ROWS*COLS-1-(r*COLS+c))*BPS +: BPS];
               lo_s   = lower_i[(ROWS*COLS-1-(r*COLS+c))*BPS +: BPS];
               vsub_s = VSUB_MASK[ROWS*COLS-1-(r*COLS+c)];
            end
         end
      end
      // top row lands in the most significant symbol
      assign beat_o[(ROWS-1-r)*BPS +: BPS] = (vsub_s && odd_line_i) ? lo_s : up_s;
   end
endmodule

// ---- vcpp_out_reg.sv ----
// output beat register that holds its beat until the sink takes it
`timescale 1ns/1ps
module vcpp_out_reg #(
   parameter int DW = 24
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 load_i,
   input  wire logic [DW-1:0]        data_i,
   input  wire vcpp_pkg::vcpp_delim_t delim_i,
   input  wire logic                 ready_i,
   output logic                      can_load_o,
   output logic                      valid_o,
   output logic [DW-1:0]             data_o,
   output vcpp_pkg::vcpp_delim_t     delim_o
);
   typedef struct packed {
      logic                  valid;
      logic [DW-1:0]         data;
      vcpp_pkg::vcpp_delim_t delim;
   } vcpp_oreg_t;

   vcpp_oreg_t st_r;
   vcpp_oreg_t st_nxt;

   assign can_load_o = !st_r.valid || ready_i;

   always_comb begin
      st_nxt = st_r;
      if (load_i && can_load_o) begin
         st_nxt.valid = 1'b1;
         st_nxt.data  = data_i;
         st_nxt.delim = delim_i;
      end else if (ready_i) begin
         st_nxt.valid = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign valid_o = st_r.valid;
   assign data_o  = st_r.data;
   assign delim_o = st_r.delim;
endmodule

// ---- vcpp_sink_model.sv ----
// sink model that takes beats at once or with stalls and watches that stalled beats hold
`timescale 1ns/1ps
module vcpp_sink_model #(
   parameter int DW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic          slow_i,
   input  wire logic          valid_i,
   input  wire logic [DW-1:0] data_i,
   input  wire logic          sop_i,
   input  wire logic          eop_i,
   output logic               ready_o,
   output logic               hold_bad_o
);
   logic [DW+1:0] got[$];
   logic [DW+1:0] last_r;
   logic          stalled_r;
   logic [1:0]    phase_r;

   always @(posedge clk_i) begin
      if (reset_i) begin
         ready_o    <= 1'b0;
         hold_bad_o <= 1'b0;
         stalled_r  <= 1'b0;
         phase_r    <= 2'h0;
      end else begin
         phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
         // slow mode accepts one cycle in three
         ready_o <= !slow_i || (phase_r == 2'h1);
         if (valid_i && ready_o) got.push_back({sop_i, eop_i, data_i});
         if (stalled_r && (!valid_i || {sop_i, eop_i, data_i} !== last_r)) hold_bad_o <= 1'b1;
         stalled_r <= valid_i && !ready_o;
         last_r    <= {sop_i, eop_i, data_i};
      end
   end
endmodule

// ---- testbench.sv ----
// testbench of the video color pattern packer against a stalling sink
`timescale 1ns/1ps
`include "vcpp_defines.svh"
module testbench;
   localparam int BPS = 8;
   localparam int ROWS = 2;
   localparam int COLS = 2;
   localparam int RC = ROWS*COLS;
   localparam bit [RC-1:0] VSUB = 4'h1;
   localparam int BW = ROWS*BPS+2;
   typedef logic [BW-1:0] vcpp_beat_t;
   logic                clk_i = 1'b0;
   logic                reset_i = 1'b1;
   logic                in_valid_i = 1'b0;
   logic                in_sop_i = 1'b0;
   logic                in_eop_i = 1'b0;
   logic                in_eol_i = 1'b0;
   logic [3:0]          in_type_i = 4'h0;
   logic [RC*BPS-1:0]   in_upper_i = '0;
   logic [RC*BPS-1:0]   in_lower_i = '0;
   logic                slow_r = 1'b0;
   logic                in_ready_o;
   logic                out_valid_o;
   logic                out_ready_i;
   logic [ROWS*BPS-1:0] out_data_o;
   logic                out_sop_o;
   logic                out_eop_o;
   logic                hold_bad;
   vcpp_beat_t          exp_q[$];
   int                  fail_count = 0;
   int                  samples_checked = 0;

   always #10 clk_i = ~clk_i;

   vcpp_packer #(.BPS(BPS), .ROWS(ROWS), .COLS(COLS), .VSUB_MASK(VSUB)) vcpp_packer_inst (
      .clk_i(clk_i), .reset_i(reset_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
      .in_sop_i(in_sop_i), .in_eop_i(in_eop_i), .in_eol_i(in_eol_i), .in_type_i(in_type_i),
      .in_upper_i(in_upper_i), .in_lower_i(in_lower_i), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .out_data_o(out_data_o), .out_sop_o(out_sop_o),
      .out_eop_o(out_eop_o));

   vcpp_sink_model #(.DW(ROWS*BPS)) vcpp_sink_model_inst (
      .clk_i(clk_i), .reset_i(reset_i), .slow_i(slow_r), .valid_i(out_valid_o),
      .data_i(out_data_o), .sop_i(out_sop_o), .eop_i(out_eop_o), .ready_o(out_ready_i),
      .hold_bad_o(hold_bad));

   task automatic check(input string what, input vcpp_beat_t seen, input vcpp_beat_t exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [ROWS*BPS-1:0] col_word(input logic [RC*BPS-1:0] up,
                                                    input logic [RC*BPS-1:0] lo,
                                                    input logic odd, input int c);
      logic [ROWS*BPS-1:0] w;
      int                  k;
      w = '0;
      for (int r = 0; r < ROWS; r++) begin
         k = RC-1-(r*COLS+c);
         w[(ROWS-1-r)*BPS +: BPS] = (VSUB[k] && odd) ? lo[k*BPS +: BPS] : up[k*BPS +: BPS];
      end
      return w;
   endfunction

   task automatic send_period(input logic sop, input logic eop, input logic eol,
                              input logic [3:0] ptype, input logic [RC*BPS-1:0] up);
      int n;
      @(posedge clk_i);
      in_valid_i <= 1'b1;
      in_sop_i   <= sop;
      in_eop_i   <= eop;
      in_eol_i   <= eol;
      in_type_i  <= ptype;
      in_upper_i <= up;
      in_lower_i <= ~up;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (in_ready_o !== 1'b1 && n < 200);
      @(posedge clk_i);
      in_valid_i <= 1'b0;
   endtask

   task automatic run_pkt(input string what, input logic [3:0] ptype, input int np,
                          input logic [7:0] eols, input logic slow);
      logic              odd;
      int                nb;
      int                n;
      logic [RC*BPS-1:0] up;
      vcpp_beat_t        got;
      odd = 1'b0;
      slow_r <= slow;
      exp_q.push_back({2'b10, {(ROWS*BPS-4){1'b0}}, ptype});
      nb = (ptype == `VCPP_TYPE_VIDEO) ? COLS : 1;
      for (int p = 0; p < np; p++) begin
         up = {8'h10, 8'h20, 8'h30, 8'h40} + {4{8'(p)}};
         for (int c = 0; c < nb; c++)
            exp_q.push_back({1'b0, (p == np-1) && (c == nb-1), col_word(up, ~up, odd, c)});
         send_period(p == 0, p == np-1, eols[p], ptype, up);
         if (eols[p]) odd = !odd;
      end
      n = 0;
      while (vcpp_sink_model_inst.got.size() < exp_q.size() && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      check({what, " count"}, BW'(vcpp_sink_model_inst.got.size()), BW'(exp_q.size()));
      while (exp_q.size() > 0 && vcpp_sink_model_inst.got.size() > 0) begin
         got = vcpp_sink_model_inst.got.pop_front();
         check({what, " beat"}, got, exp_q.pop_front());
      end
      exp_q.delete();
      vcpp_sink_model_inst.got.delete();
      check({what, " hold"}, BW'(hold_bad), '0);
      $display("test %s done", what);
   endtask

   task automatic test_video_prompt();
      run_pkt("video prompt", `VCPP_TYPE_VIDEO, 2, 8'h00, 1'b0);
   endtask

   task automatic test_video_stall();
      run_pkt("video stall", `VCPP_TYPE_VIDEO, 3, 8'h00, 1'b1);
   endtask

   task automatic test_other_types();
      run_pkt("control", `VCPP_TYPE_CTRL, 2, 8'h00, 1'b0);
      run_pkt("user", 4'h3, 2, 8'h00, 1'b1);
   endtask

   task automatic test_vsub_lines();
      run_pkt("vsub", `VCPP_TYPE_VIDEO, 3, 8'h03, 1'b0);
      run_pkt("vsub next", `VCPP_TYPE_VIDEO, 1, 8'h00, 1'b0);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(20*20000);
      fail_count++;
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      check("reset valid", BW'(out_valid_o), '0);
      check("reset ready", BW'(in_ready_o), BW'(1));
      test_video_prompt();
      test_video_stall();
      test_other_types();
      test_vsub_lines();
      give_verdict();
   end
endmodule
